// ---- logic/tws_pkg.sv ----
// Shared constants and types for the two-wire slave memory port.
package tws_pkg;

   // ------------------------------------------------------------------
   // Geometry of the memory and of a write page
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 8;
   localparam int PAGE_IDX_W = 3;
   localparam logic [ADDR_W-1:0] PTR_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Serial framing
   // ------------------------------------------------------------------
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE = 4'h1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   localparam logic DIR_READ = 1'b1;

   // Auxiliary slave address, fixed in silicon; the value is arbitrary.
   localparam logic [6:0] AUX_DEV_ADDR = 7'h3C;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int NVM_WRITE_TIME_NS = 10000;
   // Least time, so the cycle count rounds up.
   localparam int NVM_WRITE_CYCLES = (NVM_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_W = 24;

   // ------------------------------------------------------------------
   // Commit buffer
   // ------------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} tws_state_t;
   typedef enum logic [1:0] {K_DEV, K_MEM, K_DATA} tws_kind_t;

endpackage

// ---- logic/tws_slave_port.sv ----
// Two-wire slave port with page write buffer, commit FIFO and read pointer.
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Commit FIFO
// ---------------------------------------------------------------------
module tws_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW:0] wr_ptr_r, rd_ptr_r;
   logic full, empty;

   // Extra pointer bit tells full from empty when the indices meet.
   assign full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem_r[rd_ptr_r[PW-1:0]];

   // Storage write.
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem_r[wr_ptr_r[PW-1:0]] <= in_data;
      end
   end

   // Pointer update.
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule // tws_fifo

// ---------------------------------------------------------------------
// Slave port
// ---------------------------------------------------------------------
module tws_slave_port #(
   parameter int NVM_CYCLES = tws_pkg::NVM_WRITE_CYCLES,
   parameter int FIFO_DEPTH = tws_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Two-wire bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Programmable main device address.
   input wire logic [6:0] main_dev_addr,
   // Memory read port.
   output logic [tws_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [tws_pkg::DATA_W-1:0] mem_rd_data,
   // Nonvolatile write port.
   output logic nvm_wr_valid,
   input wire logic nvm_wr_ready,
   output logic [tws_pkg::ADDR_W-1:0] nvm_wr_addr,
   output logic [tws_pkg::DATA_W-1:0] nvm_wr_data,
   // Status.
   output logic nvm_busy
);
   localparam int AW = tws_pkg::ADDR_W;
   localparam int DW = tws_pkg::DATA_W;
   localparam int IW = tws_pkg::PAGE_IDX_W;
   localparam logic [IW-1:0] LAST_IDX = IW'(tws_pkg::PAGE_BYTES - 1);
   localparam logic [tws_pkg::CYC_W-1:0] LAST_CYC = tws_pkg::CYC_W'(NVM_CYCLES - 1);

   // Address match against both slave addresses.
   function automatic logic dev_match(input logic [6:0] a, input logic [6:0] main_a);
      dev_match = (a == tws_pkg::AUX_DEV_ADDR) || (a == main_a);
   endfunction

   logic scl_s1_r, scl_s2_r, scl_s3_r;
   logic sda_s1_r, sda_s2_r, sda_s3_r;
   logic scl_rise, scl_fall, start_det, stop_det;
   tws_pkg::tws_state_t state_r;
   tws_pkg::tws_kind_t kind_r;
   logic [3:0] bit_cnt_r;
   logic [DW-1:0] shift_r;
   logic rw_r, mack_r, sda_oe_r;
   logic [AW-1:0] ptr_r;
   logic byte_done, dev_accept, tx_load;
   logic [DW-1:0] page_buf_r [tws_pkg::PAGE_BYTES];
   logic [tws_pkg::PAGE_BYTES-1:0] page_vld_r;
   logic [AW-IW-1:0] page_base_r;
   logic flush_r, busy_r;
   logic [IW-1:0] flush_idx_r;
   logic [tws_pkg::CYC_W-1:0] cyc_r;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, flush_step;

   // ------------------------------------------------------------------
   // Line synchronisers
   // ------------------------------------------------------------------
   // Two flops per line, then a third stage only for edge detection.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
      end
   end

   // Edges and bus conditions; 50 MHz oversamples a 400 kHz clock amply.
   assign scl_rise = scl_s2_r & ~scl_s3_r;
   assign scl_fall = ~scl_s2_r & scl_s3_r;
   assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
   assign stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

   // ------------------------------------------------------------------
   // Byte events
   // ------------------------------------------------------------------
   // A received byte is judged on the falling edge after its eighth bit.
   assign byte_done = (state_r == tws_pkg::ST_RX) && scl_fall && (bit_cnt_r == tws_pkg::BITS_PER_BYTE);
   assign dev_accept = dev_match(shift_r[7:1], main_dev_addr) && !busy_r;
   assign tx_load = scl_fall && (((state_r == tws_pkg::ST_ACK) && (kind_r == tws_pkg::K_DEV) &&
                    rw_r) || ((state_r == tws_pkg::ST_MACK) && mack_r));

   // ------------------------------------------------------------------
   // Bit and byte sequencer
   // ------------------------------------------------------------------
   // START wins over everything but reset, so a repeated START restarts cleanly.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= tws_pkg::ST_IDLE;
         kind_r <= tws_pkg::K_DEV;
         bit_cnt_r <= tws_pkg::BIT_CNT_ZERO;
         shift_r <= '0;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (start_det) begin
         state_r <= tws_pkg::ST_RX;
         kind_r <= tws_pkg::K_DEV;
         bit_cnt_r <= tws_pkg::BIT_CNT_ZERO;
         sda_oe_r <= 1'b0;
      end else if (stop_det) begin
         state_r <= tws_pkg::ST_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         unique case (state_r)
            tws_pkg::ST_IDLE: begin
               sda_oe_r <= 1'b0;
            end
            tws_pkg::ST_RX: begin
               if (scl_rise && bit_cnt_r != tws_pkg::BITS_PER_BYTE) begin
                  shift_r <= {shift_r[DW-2:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + tws_pkg::BIT_CNT_ONE;
               end
               if (byte_done) begin
                  if (kind_r == tws_pkg::K_DEV && !dev_accept) begin
                     state_r <= tws_pkg::ST_IDLE;
                  end else begin
                     state_r <= tws_pkg::ST_ACK;
                     sda_oe_r <= 1'b1;
                     if (kind_r == tws_pkg::K_DEV) begin
                        rw_r <= (shift_r[0] == tws_pkg::DIR_READ);
                     end
                  end
               end
            end
            tws_pkg::ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= tws_pkg::BIT_CNT_ZERO;
                  if (tx_load) begin
                     state_r <= tws_pkg::ST_TX;
                     shift_r <= mem_rd_data;
                     sda_oe_r <= ~mem_rd_data[DW-1];
                  end else begin
                     state_r <= tws_pkg::ST_RX;
                     sda_oe_r <= 1'b0;
                     kind_r <= (kind_r == tws_pkg::K_DEV) ? tws_pkg::K_MEM : tws_pkg::K_DATA;
                  end
               end
            end
            tws_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == tws_pkg::LAST_TX_BIT) begin
                     state_r <= tws_pkg::ST_MACK;
                     sda_oe_r <= 1'b0;
                  end else begin
                     shift_r <= {shift_r[DW-2:0], 1'b0};
                     sda_oe_r <= ~shift_r[DW-2];
                     bit_cnt_r <= bit_cnt_r + tws_pkg::BIT_CNT_ONE;
                  end
               end
            end
            tws_pkg::ST_MACK: begin
               if (scl_rise) begin
                  mack_r <= ~sda_s2_r;
               end
               if (scl_fall) begin
                  bit_cnt_r <= tws_pkg::BIT_CNT_ZERO;
                  if (tx_load) begin
                     state_r <= tws_pkg::ST_TX;
                     shift_r <= mem_rd_data;
                     sda_oe_r <= ~mem_rd_data[DW-1];
                  end else begin
                     state_r <= tws_pkg::ST_IDLE;
                     sda_oe_r <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // Open drain: the line is only ever pulled low.
   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_r;

   // ------------------------------------------------------------------
   // Address pointer
   // ------------------------------------------------------------------
   // Writes wrap inside the page, reads wrap across the whole space.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ptr_r <= tws_pkg::PTR_RESET;
      end else if (byte_done && kind_r == tws_pkg::K_MEM) begin
         ptr_r <= shift_r;
      end else if (byte_done && kind_r == tws_pkg::K_DATA) begin
         ptr_r[IW-1:0] <= ptr_r[IW-1:0] + 1'b1;
      end else if (tx_load) begin
         ptr_r <= ptr_r + 1'b1;
      end
   end
   assign mem_rd_addr = ptr_r;

   // ------------------------------------------------------------------
   // Page buffer
   // ------------------------------------------------------------------
   // Bytes land by low pointer bits, so a ninth byte overwrites the first.
   always_ff @(posedge ref_clk) begin
      if (byte_done && kind_r == tws_pkg::K_DATA) begin
         page_buf_r[ptr_r[IW-1:0]] <= shift_r;
      end
   end

   // Valid mask: cleared by START (discard) or after the flush.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         page_vld_r <= '0;
         page_base_r <= '0;
      end else if (flush_r && flush_step && flush_idx_r == LAST_IDX) begin
         page_vld_r <= '0;
      end else if (start_det && !flush_r) begin
         page_vld_r <= '0;
      end else if (byte_done && kind_r == tws_pkg::K_DATA) begin
         page_vld_r[ptr_r[IW-1:0]] <= 1'b1;
         page_base_r <= ptr_r[AW-1:IW];
      end
   end

   // ------------------------------------------------------------------
   // Commit and self-timed write
   // ------------------------------------------------------------------
   // The flush walks all eight slots and stalls when the FIFO is full.
   assign fifo_in_valid = flush_r && page_vld_r[flush_idx_r];
   assign flush_step = !page_vld_r[flush_idx_r] || fifo_in_ready;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flush_r <= 1'b0;
         flush_idx_r <= '0;
      end else if (!flush_r && stop_det && |page_vld_r) begin
         flush_r <= 1'b1;
         flush_idx_r <= '0;
      end else if (flush_r && flush_step) begin
         flush_idx_r <= flush_idx_r + 1'b1;
         if (flush_idx_r == LAST_IDX) begin
            flush_r <= 1'b0;
         end
      end
   end

   // Busy covers flush, drain and the timed write that follows.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         busy_r <= 1'b0;
         cyc_r <= '0;
      end else if (!busy_r && stop_det && |page_vld_r) begin
         busy_r <= 1'b1;
         cyc_r <= '0;
      end else if (busy_r && !flush_r && !fifo_out_valid) begin
         if (cyc_r == LAST_CYC) begin
            busy_r <= 1'b0;
         end else begin
            cyc_r <= cyc_r + 1'b1;
         end
      end
   end

   assign nvm_busy = busy_r;
   tws_fifo #(
      .WIDTH(AW + DW),
      .DEPTH(FIFO_DEPTH)
   ) u_commit_fifo (
      .clk(ref_clk),
      .reset(reset),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({page_base_r, flush_idx_r, page_buf_r[flush_idx_r]}),
      .out_valid(fifo_out_valid),
      .out_ready(nvm_wr_ready),
      .out_data({nvm_wr_addr, nvm_wr_data})
   );
   assign nvm_wr_valid = fifo_out_valid;

endmodule // tws_slave_port

// ---- verif/tws_slave_port_asserts.sv ----
// Concurrent checks on the two-wire slave port pins and its write port.
`timescale 1ns/1ps

module tws_slave_port_asserts #(
   parameter int NVM_CYCLES = 8
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Write port and status.
   input wire logic nvm_wr_valid,
   input wire logic nvm_wr_ready,
   input wire logic [7:0] nvm_wr_addr,
   input wire logic [7:0] nvm_wr_data,
   input wire logic nvm_busy
);
   logic [15:0] idle_cnt_r;
   logic [7:0] last_addr_r;
   logic popped_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Busy cycles since the last word was offered, to time the self-timed write.
   always_ff @(posedge ref_clk) begin
      if (reset || !nvm_busy || nvm_wr_valid) begin
         idle_cnt_r <= 16'h0000;
      end else begin
         idle_cnt_r <= idle_cnt_r + 16'h0001;
      end
   end

   // Last slot handed over within one commit; cleared between commits.
   always_ff @(posedge ref_clk) begin
      if (reset || !nvm_busy) begin
         popped_r <= 1'b0;
      end else if (nvm_wr_valid && nvm_wr_ready) begin
         popped_r <= 1'b1;
         last_addr_r <= nvm_wr_addr;
      end
   end

   a_drive_low_only: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("Data pin driven high while enabled.");
   a_busy_no_ack: assert property (nvm_busy |-> !sda_oe)
      else $error("Data line pulled while the internal write runs.");
   a_valid_needs_busy: assert property (nvm_wr_valid |-> nvm_busy)
      else $error("Write offered outside a commit.");
   a_valid_held: assert property (nvm_wr_valid && !nvm_wr_ready |=>
      nvm_wr_valid && $stable(nvm_wr_addr) && $stable(nvm_wr_data))
      else $error("Offered write changed before it was taken.");
   a_page_stays: assert property (nvm_wr_valid && nvm_wr_ready && popped_r |->
      nvm_wr_addr[7:3] == last_addr_r[7:3])
      else $error("One commit left its page.");
   a_slot_ascends: assert property (nvm_wr_valid && nvm_wr_ready && popped_r |->
      nvm_wr_addr[2:0] > last_addr_r[2:0])
      else $error("Page slot written twice or out of order.");
   // A flush that skips empty slots after the queue drained adds up to six idle cycles.
   a_write_time: assert property ($fell(nvm_busy) |->
      $past(idle_cnt_r) + 3 >= NVM_CYCLES && $past(idle_cnt_r) <= NVM_CYCLES + 8)
      else $error("Self-timed write length is wrong.");
   a_change_on_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
      else $error("Data drive changed while the bus clock was high.");
   a_pull_holds: assert property ($rose(sda_oe) |-> sda_oe [*6])
      else $error("Data pull shorter than a bit slot.");
   a_commit_on_stop: assert property ($rose(nvm_busy) |-> scl_in && sda_in)
      else $error("Commit began without a STOP on the bus.");
endmodule // tws_slave_port_asserts

bind tws_slave_port tws_slave_port_asserts #(.NVM_CYCLES(NVM_CYCLES)) u_chk (
   .ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .nvm_wr_valid(nvm_wr_valid),
   .nvm_wr_ready(nvm_wr_ready), .nvm_wr_addr(nvm_wr_addr),
   .nvm_wr_data(nvm_wr_data), .nvm_busy(nvm_busy)
);

// ---- verif/tws_master_model.sv ----
// Behavioural two-wire bus master: drives the bus clock and pulls the data line.
`timescale 1ns/1ps

module tws_master_model (
   // Timing reference and resolved data line.
   input wire logic ref_clk,
   input wire logic sda_line,
   // Bus clock and open-drain pull on data.
   output logic scl,
   output logic sda_pull
);
   // The bus starts idle and the clock stands still between frames.
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Half a bus clock period; a full period is 160 ns.
   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask

   // Data moves one cycle after the clock fall, so it never races the edge.
   task automatic set_data(input logic level);
      @(negedge ref_clk);
      sda_pull = !level;
      repeat (3) @(negedge ref_clk);
   endtask

   // START from idle, or a repeated START from mid-transfer.
   task automatic start();
      if (!scl) begin
         set_data(1'b1);
         scl = 1'b1;
         half();
      end
      sda_pull = 1'b1;
      half();
      scl = 1'b0;
   endtask

   // STOP, then a long idle so the bus is seen free.
   task automatic stop();
      set_data(1'b0);
      scl = 1'b1;
      half();
      sda_pull = 1'b0;
      half();
      half();
   endtask

   // One bit slot; the line is read at the end of the high phase.
   task automatic bit_slot(input logic level, output logic seen);
      set_data(level);
      scl = 1'b1;
      half();
      seen = sda_line;
      scl = 1'b0;
   endtask

   // Byte out MSB first, then a released ninth slot for the acknowledge.
   task automatic send_byte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], s);
      end
      bit_slot(1'b1, s);
      acked = !s;
   endtask

   // Byte in; the ninth slot carries our acknowledge, or none on the last byte.
   task automatic recv_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         b[i] = s;
      end
      bit_slot(!more, s);
   endtask
endmodule // tws_master_model

// ---- verif/tws_slave_port_test.sv ----
// Self-checking bench for the two-wire slave port driven by the master model.
`timescale 1ns/1ps

module tws_slave_port_test;
   localparam logic [6:0] MAIN_ADDR = 7'h51;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic nvm_wr_ready = 1'b0;
   logic [1:0] stall_cnt = 2'h0;
   logic scl, sda_pull, sda_oe, sda_out, nvm_busy, nvm_wr_valid;
   logic [7:0] mem_rd_addr, mem_rd_data, nvm_wr_addr, nvm_wr_data;
   logic [7:0] mem [256];
   int error_cnt = 0;
   int samples_checked = 0;
   // Open-drain wire with a pull-up: any party pulling low wins.
   wire sda = !sda_pull && !(sda_oe && !sda_out);

   always #10 ref_clk = !ref_clk;

   // Memory: reads combinational, committed bytes land on the clock.
   assign mem_rd_data = mem[mem_rd_addr];
   always @(posedge ref_clk) begin
      if (nvm_wr_valid && nvm_wr_ready) begin
         mem[nvm_wr_addr] <= nvm_wr_data;
      end
   end

   // The sink stalls half the time so queued commits must wait.
   always @(negedge ref_clk) begin
      stall_cnt <= stall_cnt + 2'h1;
      nvm_wr_ready <= stall_cnt[1];
   end

   tws_slave_port #(.NVM_CYCLES(200)) u_dut (
      .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .main_dev_addr(MAIN_ADDR),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
      .nvm_wr_valid(nvm_wr_valid), .nvm_wr_ready(nvm_wr_ready),
      .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .nvm_busy(nvm_busy)
   );
   tws_master_model u_mst (.ref_clk(ref_clk), .sda_line(sda), .scl(scl), .sda_pull(sda_pull));

   function automatic logic [7:0] pat(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask

   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Bounded wait for the self-timed write; running out ends the run.
   task automatic wait_idle();
      for (int i = 0; i < 3000 && nvm_busy !== 1'b0; i++) @(negedge ref_clk);
      if (nvm_busy !== 1'b0) begin
         check({7'h00, nvm_busy}, 8'h00);
         conclude();
      end
   endtask

   task automatic tx(input logic [7:0] b, input logic exp_ack);
      logic acked;
      u_mst.send_byte(b, acked);
      check({7'h00, acked}, {7'h00, exp_ack});
   endtask

   task automatic rx(input logic more, input logic [7:0] exp);
      logic [7:0] got;
      u_mst.recv_byte(more, got);
      check(got, exp);
   endtask

   task automatic sc_addr_reads();
      u_mst.start();
      tx({7'h55, 1'b1}, 1'b0);
      tx(8'h00, 1'b0);
      u_mst.stop();
      u_mst.start();
      tx({tws_pkg::AUX_DEV_ADDR, 1'b1}, 1'b1);
      rx(1'b0, pat(8'h00));
      u_mst.stop();
   endtask

   task automatic sc_seq_read();
      u_mst.start();
      tx({MAIN_ADDR, 1'b0}, 1'b1);
      tx(8'hFE, 1'b1);
      u_mst.start();
      tx({MAIN_ADDR, 1'b1}, 1'b1);
      rx(1'b1, pat(8'hFE));
      rx(1'b1, pat(8'hFF));
      rx(1'b0, pat(8'h00));
      u_mst.stop();
   endtask

   task automatic sc_page_wrap();
      logic got;
      got = 1'b0;
      u_mst.start();
      tx({MAIN_ADDR, 1'b0}, 1'b1);
      tx(8'h06, 1'b1);
      for (int i = 0; i < 4; i++) tx(8'hC0 + 8'(i), 1'b1);
      u_mst.stop();
      u_mst.start();
      tx({MAIN_ADDR, 1'b0}, 1'b0);
      for (int i = 0; i < 20 && !got; i++) begin
         u_mst.start();
         u_mst.send_byte({MAIN_ADDR, 1'b0}, got);
      end
      u_mst.stop();
      check({7'h00, got}, 8'h01);
      wait_idle();
      check(mem[8'h06], 8'hC0);
      check(mem[8'h07], 8'hC1);
      check(mem[8'h00], 8'hC2);
      check(mem[8'h01], 8'hC3);
      check(mem[8'h02], pat(8'h02));
      u_mst.start();
      tx({MAIN_ADDR, 1'b1}, 1'b1);
      rx(1'b0, pat(8'h02));
      u_mst.stop();
   endtask

   task automatic sc_overrun();
      u_mst.start();
      tx({MAIN_ADDR, 1'b0}, 1'b1);
      tx(8'h10, 1'b1);
      for (int i = 0; i < 10; i++) tx(8'hD0 + 8'(i), 1'b1);
      u_mst.stop();
      wait_idle();
      for (int i = 0; i < 8; i++) begin
         check(mem[8'h10 + 8'(i)], (i < 2) ? 8'hD8 + 8'(i) : 8'hD0 + 8'(i));
      end
   endtask

   task automatic sc_discard();
      u_mst.start();
      tx({MAIN_ADDR, 1'b0}, 1'b1);
      tx(8'h20, 1'b1);
      tx(8'hEE, 1'b1);
      u_mst.start();
      tx({MAIN_ADDR, 1'b1}, 1'b1);
      rx(1'b0, pat(8'h21));
      u_mst.stop();
      check({7'h00, nvm_busy}, 8'h00);
      check(mem[8'h20], pat(8'h20));
   endtask

   // Reset for twelve cycles, then the scenarios in memory-dependent order.
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = pat(8'(i));
      repeat (12) @(negedge ref_clk);
      reset = 1'b0;
      repeat (3) @(negedge ref_clk);
      sc_addr_reads();
      sc_seq_read();
      sc_page_wrap();
      sc_overrun();
      sc_discard();
      conclude();
   end
endmodule // tws_slave_port_test
